//--- dsph_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dsph_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    assign in_ready  = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr];

    // storage
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // pointers and fill count
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // dsph_fifo
`default_nettype wire

//--- dsph_host_model.sv
// scan host model: test clock, mode select and serial data towards the device
`timescale 1ns/1ps
`default_nettype none
module dsph_host_model (
    // pins driven towards the device
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    // serial output of the device and its enable
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic last_q;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        last_q = 1'b0;
    end
    // one test clock period, serial output taken at the rising edge
    // inputs held through the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #213;
        q = tdo_oe ? tdo : ~last_q; // floating line gives no stale level
        last_q = q;
        tck = 1'b1;
        #107;
        tck = 1'b0;
    endtask
endmodule // dsph_host_model
`default_nettype wire

//--- dsph_pkg.sv
// types of the debug scan port
package dsph_pkg;
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
        SH_DR = 4'h4, EX1_DR = 4'h5, PS_DR = 4'h6, EX2_DR = 4'h7,
        UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
        EX1_IR = 4'hC, PS_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
    } dsph_tap_t;
    typedef enum logic [4:0] {
        I_EXTEST = 5'h00, I_SAMPLE = 5'h01, I_CPURST = 5'h10, I_DIN = 5'h11,
        I_DOUT = 5'h12, I_IFDIN = 5'h13, I_OFDOUT = 5'h14, I_CTRL = 5'h15,
        I_BYPASS = 5'h1F
    } dsph_instr_t;
endpackage

//--- dsph_regs.svh
// register offsets, field positions and reset values of the debug scan port
`ifndef DSPH_REGS_SVH
`define DSPH_REGS_SVH
`define DSPH_OFS_INBOUND   24'h103800
`define DSPH_OFS_OUTBOUND  24'h103804
`define DSPH_OFS_CTRL      24'h103808
`define DSPH_CTRL_IFULL    0
`define DSPH_CTRL_OFULL    1
`define DSPH_CTRL_SLEEPL   2
`define DSPH_SLEEPL_RST    1'h1
`define DSPH_FLAG_RST      1'h0
`define DSPH_IR_CAPT_LOW   2'h1
`define DSPH_LEN_WORD      6'h20
`define DSPH_LEN_FLAGWORD  6'h21
`define DSPH_LEN_CTRL      6'h08
`define DSPH_LEN_ONE       6'h01
`define DSPH_FIFO_DEPTH    32
`define DSPH_WORD_W        32
`endif

//--- dsph_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
`default_nettype none
module dsph_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // pin and filtered level
    input  wire logic pin_in,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // shift chain, only s2 reads s1
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s1 <= 1'h0;
            s2 <= 1'h0;
            s3 <= 1'h0;
        end
        else
        begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // level follows once second and third agree
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            level <= 1'h0;
        else if (s2 == s3)
            level <= s3;
    end
endmodule // dsph_sync
`default_nettype wire

//--- dsph_tb.sv
// self-checking bench of the debug scan port
`timescale 1ns/1ps
`default_nettype none
`include "dsph_regs.svh"
module testbench;
    import dsph_pkg::*;
    typedef struct { logic wr; logic [23:0] addr; logic [31:0] data; } dsph_row_t;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        tck, tms, tdi, tdo, tdo_oe, mmio_ready, dbg_irq, cpu_reset_req, sleepless;
    logic        mmio_wr = 1'b0;
    logic        mmio_rd = 1'b0;
    logic [23:0] mmio_addr = 24'h0;
    logic [31:0] mmio_wdata = 32'h0;
    logic [31:0] mmio_rdata;
    dsph_tap_t   tap_state;
    int          bad_count = 0;
    int          check_count = 0;
    int          irq_n = 0;
    int          cycle_n = 0;
    // plain register accesses: reads carry the expected word
    dsph_row_t rows [12] = '{
        '{1'b0, `DSPH_OFS_CTRL, 32'h4}, '{1'b1, `DSPH_OFS_OUTBOUND, 32'h3C5A96E1},
        '{1'b0, `DSPH_OFS_OUTBOUND, 32'h3C5A96E1}, '{1'b1, `DSPH_OFS_INBOUND, 32'h0F1E2D3C},
        '{1'b0, `DSPH_OFS_INBOUND, 32'h0F1E2D3C}, '{1'b1, 24'h10380C, 32'hFFFFFFFF},
        '{1'b0, 24'h10380C, 32'h0}, '{1'b0, `DSPH_OFS_CTRL, 32'h4}, '{1'b1, `DSPH_OFS_CTRL, 32'h2},
        '{1'b0, `DSPH_OFS_CTRL, 32'h2}, '{1'b1, `DSPH_OFS_CTRL, 32'h6}, '{1'b0, `DSPH_OFS_CTRL, 32'h6}};
    dsph_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .mmio_addr(mmio_addr), .mmio_wr(mmio_wr), .mmio_rd(mmio_rd), .mmio_wdata(mmio_wdata),
        .mmio_rdata(mmio_rdata), .mmio_ready(mmio_ready), .dbg_irq(dbg_irq), .cpu_reset_req(cpu_reset_req),
        .sleepless(sleepless), .tap_state(tap_state));
    dsph_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
    // clock, interrupt pulse count and hang guard
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (dbg_irq === 1'b1)
            irq_n <= irq_n + 1;
        cycle_n <= cycle_n + 1;
        if (cycle_n == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [32:0] s, input logic [32:0] e);
        check_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one-cycle strobe, answer taken while ready stands
    task automatic mmio(input logic w, input logic [23:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        mmio_wr <= w;
        mmio_rd <= ~w;
        mmio_addr <= a;
        mmio_wdata <= d;
        @(posedge core_clk);
        mmio_wr <= 1'b0;
        mmio_rd <= 1'b0;
        @(negedge core_clk);
        chk("mmio_ready", {32'h0, mmio_ready}, 33'h1);
        q = mmio_rdata;
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] e);
        logic [31:0] q;
        mmio(1'b0, a, 32'h0, q);
        chk("mmio_rdata", {1'b0, q}, {1'b0, e});
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        logic [31:0] q;
        mmio(1'b1, a, d, q);
    endtask
    // one test clock period with the data line parked at its inverse
    task automatic go(input logic m);
        logic q;
        host.step(m, ~tdi, q);
    endtask
    // scan from idle back to idle, least significant bit first
    task automatic scan(input logic ir, input int n, input logic [32:0] din, output logic [32:0] dout);
        dout = 33'h0;
        go(1'b1);
        if (ir)
            go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int i = 0; i < n; i++)
            host.step(i == n - 1, din[i], dout[i]);
        go(1'b1);
        go(1'b0);
        // let the update cross into the core domain
        repeat (8) @(negedge core_clk);
    endtask
    task automatic set_ir(input logic [4:0] code, input logic [4:0] cap);
        logic [32:0] d;
        scan(1'b1, 5, {28'h0, code}, d);
        chk("ir_capture", d, {28'h0, cap});
    endtask
    initial
    begin
        logic [32:0] d;
        int n0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk("tap_state", {29'h0, tap_state}, {29'h0, TLR});
        chk("sleepless", {32'h0, sleepless}, 33'h1);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr(rows[i].addr, rows[i].data);
            else
                rd(rows[i].addr, rows[i].data);
        end
        // mode select high holds reset, low moves to idle
        repeat (4) go(1'b1);
        chk("tap_state", {29'h0, tap_state}, {29'h0, TLR});
        go(1'b0);
        repeat (6) @(negedge core_clk);
        chk("tap_state", {29'h0, tap_state}, {29'h0, RTI});
        chk("tdo_oe", {32'h0, tdo_oe}, 33'h0);
        // outbound word scanned twice, flag kept then cleared
        set_ir(I_OFDOUT, 5'h19);
        scan(1'b0, 33, 33'h0, d);
        chk("out_scan", d, {1'b1, 32'h3C5A96E1});
        rd(`DSPH_OFS_CTRL, 32'h6);
        scan(1'b0, 33, {1'b1, 32'hFFFFFFFF}, d);
        chk("out_scan", d, {1'b1, 32'h3C5A96E1});
        rd(`DSPH_OFS_CTRL, 32'h4);
        rd(`DSPH_OFS_OUTBOUND, 32'h3C5A96E1);
        // head word plus full queue, one post dropped, last post with flag low
        set_ir(I_IFDIN, 5'h11);
        n0 = irq_n;
        for (int k = 0; k < 35; k++)
            scan(1'b0, 33, {k < 34, 32'hC0DE0000 + k}, d);
        repeat (6) @(negedge core_clk);
        chk("irq_count", irq_n - n0, 33'h21);
        rd(`DSPH_OFS_CTRL, 32'h5);
        for (int k = 0; k < 33; k++)
        begin
            rd(`DSPH_OFS_INBOUND, 32'hC0DE0000 + k);
            wr(`DSPH_OFS_CTRL, 32'h4);
            repeat (2) @(posedge core_clk);
        end
        rd(`DSPH_OFS_CTRL, 32'h4);
        // bypass delays the stream by one edge
        set_ir(I_BYPASS, 5'h11);
        scan(1'b0, 8, 33'hB4, d);
        chk("bypass", d, 33'h68);
        set_ir(I_CPURST, 5'h11);
        repeat (6) @(negedge core_clk);
        chk("cpu_reset_req", {32'h0, cpu_reset_req}, 33'h1);
        wr(`DSPH_OFS_CTRL, 32'h2);
        chk("sleepless", {32'h0, sleepless}, 33'h0);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk("tap_state", {29'h0, tap_state}, {29'h0, TLR});
        chk("cpu_reset_req", {32'h0, cpu_reset_req}, 33'h0);
        chk("sleepless", {32'h0, sleepless}, 33'h1);
        rd(`DSPH_OFS_CTRL, 32'h4);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire

//--- dsph_top.sv
// debug scan port: tap controller, handshake registers and mmio mailbox
// Functional notes
// R01 - no test clock edge seen means no state changes at all
// R02 - mode select sampled at each rising test clock edge steers next state
// R03 - serial input taken on rising test clock edge
// R04 - serial bits leave uninverted after selected register length edges
// R05 - serial output changes only after falling test clock edge
// R06 - serial output enabled only during instruction or data shift
// R07 - controller starts in test-logic-reset after reset
// R08 - mode select high keeps controller in test-logic-reset
// R09 - mode select low leaves reset for idle; idle rests between scans
// R10 - updated instruction selects exactly one data register
// R11 - host scans selecting instruction before scanning data register
// R12 - shift stage separate; parallel stage changes only at update
// R13 - capture parallel value, shift n bits both ways, load at update
// R14 - read-only registers unchanged by update
// R15 - handshake flags: shifted bit decides keep or action at update
// R16 - test clock asynchronous; no phase relation to core clock assumed
// R17 - host supplies test clock, mode select and serial data
// R18 - five-bit instruction; 10001 inbound, 11111 bypass, others as listed
// R19 - scanned one into inbound-full raises processor interrupt line; with 32 words queued the word is dropped and no pulse is raised
// R20 - scanned one clears outbound-full, zero keeps; resets to zero
// R21 - instruction capture loads 01 then control bits 0 to 2
// R22 - flags cross between scan and core domains through synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "dsph_regs.svh"
module dsph_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // scan pins
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    output logic             tdo_oe,
    // processor load/store access
    input  wire logic [23:0] mmio_addr,
    input  wire logic        mmio_wr,
    input  wire logic        mmio_rd,
    input  wire logic [31:0] mmio_wdata,
    output logic [31:0]      mmio_rdata,
    output logic             mmio_ready,
    // processor side events
    output logic             dbg_irq,
    output logic             cpu_reset_req,
    output logic             sleepless,
    output dsph_pkg::dsph_tap_t tap_state
);
    import dsph_pkg::*;

    logic        tck_lvl;
    logic        tms_lvl;
    logic        tdi_lvl;
    logic        tck_prev;
    logic        tck_rise;
    logic        tck_fall;
    dsph_tap_t   next_tap;
    dsph_instr_t instr;
    logic [32:0] shreg;
    logic [5:0]  cur_len;
    logic [31:0] stage_word;
    logic [31:0] inbound_word;
    logic        inbound_valid;
    logic [31:0] outbound_word;
    logic        ofull;
    logic        push_req;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic        cpu_clr_ifull;
    logic        cpu_set_ofull;
    logic        scan_clr_ofull;
    logic        upd_dr;

    // length of the data register picked by an instruction
    function automatic logic [5:0] dr_len(input dsph_instr_t ir);
        unique case (ir)
            I_DIN, I_DOUT:     dr_len = `DSPH_LEN_WORD;
            I_IFDIN, I_OFDOUT: dr_len = `DSPH_LEN_FLAGWORD;
            I_CTRL:            dr_len = `DSPH_LEN_CTRL;
            default:           dr_len = `DSPH_LEN_ONE;
        endcase
    endfunction

    // R16 pins synchronised
    dsph_sync u_sync_tck (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (tck),
        .level    (tck_lvl)
    );
    dsph_sync u_sync_tms (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (tms),
        .level    (tms_lvl)
    );
    dsph_sync u_sync_tdi (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (tdi),
        .level    (tdi_lvl)
    );

    // test clock edge detection
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            tck_prev <= 1'h0;
        else
            tck_prev <= tck_lvl;
    end
    assign tck_rise = tck_lvl & ~tck_prev;
    assign tck_fall = ~tck_lvl & tck_prev;

    // tap next state from sampled mode select
    always_comb
    begin
        unique case (tap_state)
            TLR:    next_tap = tms_lvl ? TLR : RTI;
            RTI:    next_tap = tms_lvl ? SEL_DR : RTI;
            SEL_DR: next_tap = tms_lvl ? SEL_IR : CAP_DR;
            CAP_DR: next_tap = tms_lvl ? EX1_DR : SH_DR;
            SH_DR:  next_tap = tms_lvl ? EX1_DR : SH_DR;
            EX1_DR: next_tap = tms_lvl ? UPD_DR : PS_DR;
            PS_DR:  next_tap = tms_lvl ? EX2_DR : PS_DR;
            EX2_DR: next_tap = tms_lvl ? UPD_DR : SH_DR;
            UPD_DR: next_tap = tms_lvl ? SEL_DR : RTI;
            SEL_IR: next_tap = tms_lvl ? TLR : CAP_IR;
            CAP_IR: next_tap = tms_lvl ? EX1_IR : SH_IR;
            SH_IR:  next_tap = tms_lvl ? EX1_IR : SH_IR;
            EX1_IR: next_tap = tms_lvl ? UPD_IR : PS_IR;
            PS_IR:  next_tap = tms_lvl ? EX2_IR : PS_IR;
            EX2_IR: next_tap = tms_lvl ? UPD_IR : SH_IR;
            UPD_IR: next_tap = tms_lvl ? SEL_DR : RTI;
        endcase
    end

    // R07 reset into test-logic-reset
    // R02 advance only on rising test clock
    // R08 R09 held by next-state table
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            tap_state <= TLR;
        else if (tck_rise)
            tap_state <= next_tap;
    end

    // R10 R18 instruction parallel stage
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            instr <= I_BYPASS;
        else if (tck_rise && tap_state == TLR)
            instr <= I_BYPASS;
        else if (tck_rise && tap_state == UPD_IR)
            instr <= dsph_instr_t'(shreg[4:0]);
    end
    assign cur_len = (tap_state inside {CAP_IR, SH_IR}) ? 6'h05 : dr_len(instr);

    // R13 capture then shift; R21 instruction capture value
    // R03 serial input taken on rising edge
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            shreg <= '0;
        else if (tck_rise)
        begin
            unique case (tap_state)
                CAP_IR: shreg <= {28'h0, sleepless, ofull, inbound_valid, `DSPH_IR_CAPT_LOW};
                CAP_DR:
                    unique case (instr)
                        I_DIN:    shreg <= {1'h0, inbound_word};
                        I_DOUT:   shreg <= {1'h0, outbound_word};
                        I_IFDIN:  shreg <= {inbound_valid, inbound_word};
                        I_OFDOUT: shreg <= {ofull, outbound_word};
                        I_CTRL:   shreg <= {30'h0, sleepless, ofull, inbound_valid};
                        default:  shreg <= '0;
                    endcase
                // R04 uninverted, length of selected register
                SH_IR, SH_DR:
                begin
                    shreg <= shreg >> 1;
                    shreg[cur_len - 6'h01] <= tdi_lvl;
                end
                default: shreg <= shreg;
            endcase
        end
    end

    // R05 R06 output moves on falling edge, enabled only in shift
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end
        else if (tck_fall)
        begin
            tdo    <= shreg[0];
            tdo_oe <= (tap_state == SH_IR) || (tap_state == SH_DR);
        end
    end

    // R12 parallel stages touched only at update
    assign upd_dr = tck_rise && (tap_state == UPD_DR);

    // staged inbound word written by scan
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            stage_word <= '0;
        else if (upd_dr && (instr == I_DIN || instr == I_IFDIN))
            stage_word <= shreg[31:0];
    end

    // R15 R19 flag bit one posts the word, zero remembers
    always_comb
    begin
        push_req = 1'h0;
        if (upd_dr && instr == I_IFDIN)
            push_req = shreg[32];
        else if (upd_dr && instr == I_CTRL)
            push_req = shreg[`DSPH_CTRL_IFULL];
    end

    // inbound word queue toward the processor
    dsph_fifo #(
        .W (`DSPH_WORD_W),
        .D (`DSPH_FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (push_req),
        .in_ready  (fifo_in_ready),
        .in_data   (upd_dr && instr == I_IFDIN ? shreg[31:0] : stage_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );
    assign fifo_out_ready = ~inbound_valid | cpu_clr_ifull;

    // R19 interrupt pulse when a posted word is accepted
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            dbg_irq <= 1'h0;
        else
            dbg_irq <= push_req & fifo_in_ready;
    end

    // processor strobes into control register
    assign cpu_clr_ifull = mmio_wr && mmio_addr == `DSPH_OFS_CTRL && !mmio_wdata[`DSPH_CTRL_IFULL];
    assign cpu_set_ofull = mmio_wr && mmio_addr == `DSPH_OFS_CTRL && mmio_wdata[`DSPH_CTRL_OFULL];
    // R14 R15 R20 outbound word read-only from scan; one clears flag
    assign scan_clr_ofull = upd_dr && ((instr == I_OFDOUT && shreg[32]) ||
                                       (instr == I_CTRL && shreg[`DSPH_CTRL_OFULL]));

    // R22 inbound word and flag, refilled from queue, clear loses to refill
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            inbound_word  <= '0;
            inbound_valid <= `DSPH_FLAG_RST;
        end
        else
        begin
            if (fifo_out_valid && fifo_out_ready)
            begin
                inbound_word  <= fifo_out_data;
                inbound_valid <= 1'h1;
            end
            else if (cpu_clr_ifull)
                inbound_valid <= 1'h0;
            if (mmio_wr && mmio_addr == `DSPH_OFS_INBOUND)
                inbound_word <= mmio_wdata;
        end
    end

    // R20 outbound flag, processor set wins over scan clear
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            ofull <= `DSPH_FLAG_RST;
        else if (cpu_set_ofull)
            ofull <= 1'h1;
        else if (scan_clr_ofull)
            ofull <= 1'h0;
    end

    // outbound word written by the processor only
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            outbound_word <= '0;
        else if (mmio_wr && mmio_addr == `DSPH_OFS_OUTBOUND)
            outbound_word <= mmio_wdata;
    end

    // keep-awake bit, writable from both sides
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            sleepless <= `DSPH_SLEEPL_RST;
        else if (mmio_wr && mmio_addr == `DSPH_OFS_CTRL)
            sleepless <= mmio_wdata[`DSPH_CTRL_SLEEPL];
        else if (upd_dr && instr == I_CTRL)
            sleepless <= shreg[`DSPH_CTRL_SLEEPL];
    end

    // processor reset request while reset instruction stands
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            cpu_reset_req <= 1'h0;
        else
            cpu_reset_req <= (instr == I_CPURST);
    end

    // register read data
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            mmio_rdata <= '0;
        else if (mmio_rd)
        begin
            unique case (mmio_addr)
                `DSPH_OFS_INBOUND:  mmio_rdata <= inbound_word;
                `DSPH_OFS_OUTBOUND: mmio_rdata <= outbound_word;
                `DSPH_OFS_CTRL:     mmio_rdata <= {29'h0, sleepless, ofull, inbound_valid};
                default:            mmio_rdata <= '0;
            endcase
        end
    end

    // access always completes next cycle
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            mmio_ready <= 1'h0;
        else
            mmio_ready <= mmio_rd | mmio_wr;
    end
endmodule // dsph_top
`default_nettype wire

//--- dsph_top_asserts.sv
// pin-level assertions for the debug scan port top module
`timescale 1ns/1ps
`default_nettype none
module dsph_top_asserts (
    // clock and reset
    input wire logic                core_clk,
    input wire logic                sys_rst,
    // watched pins
    input wire logic                tck,
    input wire logic                tms,
    input wire logic                tdo,
    input wire logic                tdo_oe,
    input wire logic                dbg_irq,
    input wire dsph_pkg::dsph_tap_t tap_state
);
    import dsph_pkg::*;
    logic [3:0] low_n;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // cycles the test clock pin has stood low
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || tck)
            low_n <= 4'h0;
        else if (low_n != 4'hF)
            low_n <= low_n + 4'h1;
    end
    sequence s_tms_high;
        tms [*6];
    endsequence
    sequence s_irq_pulse;
        dbg_irq ##1 !dbg_irq;
    endsequence
    a_reset_tlr: assert property ($fell(sys_rst) |-> tap_state == TLR)
        else $error("tap not in reset state after reset");
    a_tms_holds_tlr: assert property ((s_tms_high ##0 tap_state == TLR) |=> tap_state == TLR)
        else $error("tap left reset state with mode select high");
    a_tlr_exit_idle: assert property (tap_state == TLR |=> tap_state inside {TLR, RTI})
        else $error("tap left reset state for other than idle");
    a_stall_holds: assert property (low_n > 4'h5 |=> $stable(tap_state))
        else $error("tap state moved with test clock stopped low");
    a_move_on_rise: assert property ($changed(tap_state) |-> $past(tck, 2) || $past(tck, 3))
        else $error("tap state moved without a rising test clock");
    a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 2) || !$past(tck, 3))
        else $error("serial output moved without a falling test clock");
    a_oe_in_shift: assert property (tdo_oe |-> tap_state inside {SH_DR, SH_IR, EX1_DR, EX1_IR})
        else $error("serial output driven outside a shift");
    a_irq_on_update: assert property ($rose(dbg_irq) |-> $past(tap_state) == UPD_DR ##0 s_irq_pulse)
        else $error("interrupt pulse outside data update");
endmodule // dsph_top_asserts
bind dsph_top dsph_top_asserts u_asserts (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdo(tdo), .tdo_oe(tdo_oe), .dbg_irq(dbg_irq), .tap_state(tap_state));
`default_nettype wire
